// [include/smp_page_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface smp_page_if #(
  parameter int AW = 3
);
  logic          wr;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;

  modport host (output wr, output addr, output wdata, input rdata);
  modport page (input wr, input addr, input wdata, output rdata);
endinterface : smp_page_if

`default_nettype wire

// [include/smp_pkg.sv]
package smp_pkg;

  // ==========================================================
  // Address map (byte addresses within a 256-entry area)
  localparam int          SMP_AREA_SPAN      = 256;
  localparam int          SMP_ADDR_W         = $clog2(SMP_AREA_SPAN);
  localparam logic [7:0]  SMP_SYSTEM_CONTROL_ZERO_ADDR   = 8'h8F;
  localparam logic [7:0]  SMP_PASSWORD_PROTECTION_ADDR    = 8'hBB;
  localparam logic [7:0]  SMP_PROT_CTRL_ADDR = 8'hBC;
  localparam logic [7:0]  SMP_PAGE_BASE      = 8'hC0;
  localparam int          SMP_PAGE_WIN_W     = 3;

  // ==========================================================
  // System control field layout and reset
  localparam int          SMP_AREA_BIT       = 0;
  localparam int          SMP_RSV_ONE_BIT    = 2;
  localparam int          SMP_IMODE_BIT      = 4;
  localparam logic [7:0]  SMP_SYSTEM_CONTROL_ZERO_RST    = 8'h04;

  // ==========================================================
  // Password register field layout, reset and patterns
  localparam int          SMP_MODE_LSB       = 0;
  localparam int          SMP_STATUS_BIT     = 2;
  localparam int          SMP_PASS_LSB       = 3;
  localparam logic [7:0]  SMP_PASSWORD_PROTECTION_RST     = 8'h07;
  localparam logic [1:0]  SMP_MODE_RST       = 2'h3;
  localparam logic [1:0]  SMP_MODE_OFF       = 2'h0;
  localparam logic        SMP_LOCK_RST       = 1'b1;
  localparam logic [4:0]  SMP_PASS_MODE      = 5'h18;
  localparam logic [4:0]  SMP_PASS_OPEN      = 5'h13;
  localparam logic [4:0]  SMP_PASS_CLOSE     = 5'h15;
  localparam logic [7:0]  SMP_PROT_CTRL_RST  = 8'h00;

  // ==========================================================
  // Helpers
  function automatic logic smp_in_window(input logic [7:0] addr,
                                         input logic [7:0] base,
                                         input int         win_w);
    logic [7:0] mask;
    mask = 8'hFF << win_w;
    return (addr & mask) == (base & mask);
  endfunction : smp_in_window

endpackage : smp_pkg

// [tb/smp_top_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module smp_top_checker
  import smp_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata_q,
  // Observed state
  input wire logic       fwd_wr_q,
  input wire logic       fwd_area_q,
  input wire logic [7:0] fwd_addr_q,
  input wire logic       area_select_q,
  input wire logic       idle_mode_q,
  input wire logic       prot_locked_q,
  input wire logic [1:0] prot_mode_q,
  input wire logic [7:0] prot_ctrl_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Access steps
  sequence s_pwd_wr;
    wr && !area_select_q && addr == SMP_PASSWORD_PROTECTION_ADDR;
  endsequence
  // Lock output lags one cycle, so skip writes right after another write
  sequence s_ctl_wr;
    wr && !area_select_q && addr == SMP_PROT_CTRL_ADDR && !$past(wr);
  endsequence
  // ==========================================================
  // Properties
  chk_area_write: assert property (
    wr && addr == SMP_SYSTEM_CONTROL_ZERO_ADDR |=> area_select_q == $past(wdata[0]))
    else $error("area select not loaded");
  chk_sys_read: assert property (
    rd && addr == SMP_SYSTEM_CONTROL_ZERO_ADDR |=> rdata_q == {3'h0, idle_mode_q, 3'h2, area_select_q})
    else $error("system control read wrong");
  chk_rdata_idle: assert property (!rd |=> rdata_q == 8'h00)
    else $error("read data outside read");
  chk_mode_hold: assert property (
    !(wr && !area_select_q && addr == SMP_PASSWORD_PROTECTION_ADDR && wdata[7:3] == SMP_PASS_MODE)
    |=> $stable(prot_mode_q)) else $error("mode changed without password");
  chk_mode_load: assert property (
    s_pwd_wr ##0 wdata[7:3] == SMP_PASS_MODE |=> prot_mode_q == $past(wdata[1:0]))
    else $error("mode not loaded");
  chk_pwd_read: assert property (
    rd && !area_select_q && addr == SMP_PASSWORD_PROTECTION_ADDR
    |=> rdata_q == {5'h00, prot_locked_q, prot_mode_q}) else $error("password read wrong");
  chk_lock_drop: assert property (s_ctl_wr ##0 prot_locked_q |=> $stable(prot_ctrl_q))
    else $error("locked write taken");
  chk_open_write: assert property (
    s_ctl_wr ##0 !prot_locked_q |=> prot_ctrl_q == $past(wdata)) else $error("open write lost");
  chk_mode_off: assert property (
    $stable(prot_mode_q) && prot_mode_q == SMP_MODE_OFF |-> !prot_locked_q)
    else $error("locked while disabled");
  chk_fwd_access: assert property (
    fwd_wr_q |-> $past(wr) && fwd_addr_q == $past(addr) && fwd_area_q == $past(area_select_q))
    else $error("forwarded write wrong");
endmodule : smp_top_checker

bind smp_top smp_top_checker u_chk (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata_q,
  .fwd_wr_q, .fwd_area_q, .fwd_addr_q, .area_select_q, .idle_mode_q, .prot_locked_q,
  .prot_mode_q, .prot_ctrl_q);
`default_nettype wire

// [tb/smp_top_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module smp_top_bench
  import smp_pkg::*;
;
  logic       clk, rst_n, wr, rd, fwd_wr_q, fwd_rd_q, fwd_area_q;
  logic       area_select_q, idle_mode_q, prot_locked_q;
  logic [7:0] addr, wdata, rdata_q, fwd_addr_q, fwd_wdata_q, prot_ctrl_q;
  logic [7:0] r, d, ctrl_m;
  logic [7:0] pv [4];
  logic [4:0] p;
  logic [1:0] prot_mode_q, mode_m;
  logic       lock_m;
  int         fails, samples_checked;

  smp_top #(.PAGES(4), .REGS(7)) dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata_q,
    .fwd_wr_q, .fwd_rd_q, .fwd_area_q, .fwd_addr_q, .fwd_wdata_q, .area_select_q,
    .idle_mode_q, .prot_locked_q, .prot_mode_q, .prot_ctrl_q);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] pwd_exp();
    return {5'h00, (mode_m != SMP_MODE_OFF) && lock_m, mode_m};
  endfunction : pwd_exp
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : put
  task automatic get(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata_q;
  endtask : get
  task automatic close_out();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // ==========================================================
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end

  // ==========================================================
  // Tests
  initial
  begin
    rst_n = 1'b0;
    {wr, rd, addr, wdata} = 18'h0_0000;
    mode_m = SMP_MODE_RST;
    lock_m = SMP_LOCK_RST;
    ctrl_m = 8'h00;
    void'($urandom(60593));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    get(SMP_SYSTEM_CONTROL_ZERO_ADDR);
    check(r, SMP_SYSTEM_CONTROL_ZERO_RST);
    get(SMP_PASSWORD_PROTECTION_ADDR);
    check(r, pwd_exp());
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      put(SMP_SYSTEM_CONTROL_ZERO_ADDR, d);
      get(SMP_SYSTEM_CONTROL_ZERO_ADDR);
      check(r, {3'h0, d[4], 3'h2, d[0]});
    end
    // Mapped area by read-modify-write: password address is forwarded there
    get(SMP_SYSTEM_CONTROL_ZERO_ADDR);
    put(SMP_SYSTEM_CONTROL_ZERO_ADDR, r | 8'h01);
    put(SMP_PASSWORD_PROTECTION_ADDR, {SMP_PASS_MODE, 3'h0});
    check({4'h0, fwd_wr_q, fwd_area_q, prot_mode_q}, {4'h0, 2'h3, SMP_MODE_RST});
    check(fwd_addr_q, SMP_PASSWORD_PROTECTION_ADDR);
    check(fwd_wdata_q, {SMP_PASS_MODE, 3'h0});
    get(8'h10);
    check({fwd_rd_q, r[6:0]}, 8'h80);
    for (int i = 0; i < 4; i++)
    begin
      pv[i] = 8'($urandom);
      put(SMP_PAGE_BASE, 8'(i));
      put(SMP_PAGE_BASE + 8'h07, pv[i]);
    end
    for (int i = 3; i >= 0; i--)
    begin
      put(SMP_PAGE_BASE, 8'(i));
      get(SMP_PAGE_BASE + 8'h07);
      check(r, pv[i]);
    end
    get(SMP_SYSTEM_CONTROL_ZERO_ADDR);
    put(SMP_SYSTEM_CONTROL_ZERO_ADDR, r & 8'hFE);
    for (int i = 0; i < 6; i++)
    begin
      p = 5'($urandom);
      if (p == SMP_PASS_MODE || p == SMP_PASS_OPEN || p == SMP_PASS_CLOSE)
        p = p ^ 5'h01;
      put(SMP_PASSWORD_PROTECTION_ADDR, {p, 3'h0});
      put(SMP_PROT_CTRL_ADDR, 8'($urandom));
      get(SMP_PASSWORD_PROTECTION_ADDR);
      check(r, pwd_exp());
      check(prot_ctrl_q, ctrl_m);
    end
    for (int m = 0; m < 4; m++)
    begin
      mode_m = m[1:0];
      put(SMP_PASSWORD_PROTECTION_ADDR, {SMP_PASS_MODE, 1'b0, mode_m});
      get(SMP_PASSWORD_PROTECTION_ADDR);
      check(r, pwd_exp());
      d = 8'($urandom);
      if (mode_m == SMP_MODE_OFF)
        ctrl_m = d;
      put(SMP_PROT_CTRL_ADDR, d);
      check(prot_ctrl_q, ctrl_m);
    end
    for (int k = 0; k < 2; k++)
    begin
      lock_m = k[0];
      put(SMP_PASSWORD_PROTECTION_ADDR, {k ? SMP_PASS_CLOSE : SMP_PASS_OPEN, 3'h0});
      get(SMP_PASSWORD_PROTECTION_ADDR);
      check(r, pwd_exp());
      check({7'h00, prot_locked_q}, {7'h00, lock_m});
      d = 8'($urandom);
      if (!lock_m)
        ctrl_m = d;
      put(SMP_PROT_CTRL_ADDR, d);
      check(prot_ctrl_q, ctrl_m);
    end
    close_out();
  end
endmodule : smp_top_bench
`default_nettype wire

// [verilog/smp_paged_regs.sv]
`timescale 1ns/10ps
`default_nettype none

module smp_paged_regs
  import smp_pkg::*;
#(
  parameter int PAGES = 4,
  parameter int REGS  = 7
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Local register access
  smp_page_if.page  bus
);

  localparam int PW = (PAGES > 1) ? $clog2(PAGES) : 1;
  localparam int AW = SMP_PAGE_WIN_W;

  logic [PW-1:0] page_q;
  logic [7:0]    mem_q [PAGES][REGS];
  logic          page_ok;
  logic          reg_ok;
  int unsigned   idx;

  // ==========================================================
  // Local decode: offset 0 is the page register
  always_comb
  begin
    idx     = 32'(bus.addr) - 1;
    page_ok = 32'(page_q) < PAGES;
    reg_ok  = (bus.addr != '0) && (32'(bus.addr) <= REGS);
  end

  // ==========================================================
  // Page register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      page_q <= '0;
    else if (bus.wr && bus.addr == '0)
      page_q <= bus.wdata[PW-1:0];
  end

  // ==========================================================
  // Paged registers, target chosen by the page field
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int p = 0; p < PAGES; p++)
        for (int r = 0; r < REGS; r++)
          mem_q[p][r] <= 8'h00;
    end
    else if (bus.wr && reg_ok && page_ok)
      mem_q[page_q][idx] <= bus.wdata;
  end

  // ==========================================================
  // Read path; invalid page or offset reads zero
  always_comb
  begin
    bus.rdata = 8'h00;
    if (bus.addr == '0)
      bus.rdata = 8'(page_q);
    else if (reg_ok && page_ok)
      bus.rdata = mem_q[page_q][idx];
  end

endmodule : smp_paged_regs

`default_nettype wire

// [verilog/smp_top.sv]
// Overview of operation
// - Area select at system control bit 0 routes accesses between areas.
// - Area select one picks mapped area, zero picks standard area.
// - System control bit 2 reads one; software writes one.
// - System control bits 7:5, 3 and 1 read zero; software writes zero.
// - Each area spans 256 register addresses.
// - Paged module picks its register by its page field, programmed first.
// - Each paged module sets its own page and register counts.
// - Mode 00 disables protection; protected bits write freely.
// - Mode 11 is reset default; any nonzero mode enables protection.
// - Mode ignores direct writes; loads only with password 11000.
// - Status bit 2 reads zero when writable, one when locked.
// - Password 10011 opens write access to protected bits.
// - Password 10101 closes write access to protected bits.
// - Only three patterns act; any other password does nothing.
`timescale 1ns/10ps
`default_nettype none

module smp_top
  import smp_pkg::*;
#(
  parameter int PAGES = 4,
  parameter int REGS  = 7
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata_q,
  // Forwarded accesses to other registers
  output logic            fwd_wr_q,
  output logic            fwd_rd_q,
  output logic            fwd_area_q,
  output logic      [7:0] fwd_addr_q,
  output logic      [7:0] fwd_wdata_q,
  // Control and status
  output logic            area_select_q,
  output logic            idle_mode_q,
  output logic            prot_locked_q,
  output logic      [1:0] prot_mode_q,
  output logic      [7:0] prot_ctrl_q
);

  // ==========================================================
  // Declarations
  logic       lock_q;
  logic       scheme_on;
  logic       locked;
  logic       hit_sys;
  logic       hit_pw;
  logic       hit_pc;
  logic       hit_pg;
  logic       hit_any;
  logic [4:0] pass;
  logic [7:0] rdata_d;
  logic [7:0] sys_view;
  logic [7:0] pw_view;

  smp_page_if #(.AW(SMP_PAGE_WIN_W)) pg_bus ();

  // ==========================================================
  // Address decode
  always_comb
  begin
    // System control reachable in either area
    hit_sys = (addr == SMP_SYSTEM_CONTROL_ZERO_ADDR);
    // Standard area when area select is zero
    hit_pw  = !area_select_q && (addr == SMP_PASSWORD_PROTECTION_ADDR);
    hit_pc  = !area_select_q && (addr == SMP_PROT_CTRL_ADDR);
    // Mapped area when area select is one
    hit_pg  = area_select_q
              && smp_in_window(addr, SMP_PAGE_BASE, SMP_PAGE_WIN_W);
    hit_any = hit_sys || hit_pw || hit_pc || hit_pg;
    pass    = wdata[SMP_PASS_LSB +: 5];
  end

  // ==========================================================
  // Protection state
  always_comb
  begin
    scheme_on = (prot_mode_q != SMP_MODE_OFF);
    locked    = scheme_on && lock_q;
  end

  // ==========================================================
  // System control register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      area_select_q <= SMP_SYSTEM_CONTROL_ZERO_RST[SMP_AREA_BIT];
      idle_mode_q   <= SMP_SYSTEM_CONTROL_ZERO_RST[SMP_IMODE_BIT];
    end
    else if (wr && hit_sys)
    begin
      area_select_q <= wdata[SMP_AREA_BIT];
      idle_mode_q   <= wdata[SMP_IMODE_BIT];
    end
  end

  // ==========================================================
  // Protection mode, loaded only with the mode password
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prot_mode_q <= SMP_MODE_RST;
    else if (wr && hit_pw && pass == SMP_PASS_MODE)
      prot_mode_q <= wdata[SMP_MODE_LSB +: 2];
  end

  // ==========================================================
  // Open and close of protected bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lock_q <= SMP_LOCK_RST;
    else if (wr && hit_pw)
    begin
      unique case (pass)
        SMP_PASS_OPEN:  lock_q <= 1'b0;
        SMP_PASS_CLOSE: lock_q <= 1'b1;
        default:        lock_q <= lock_q;
      endcase
    end
  end

  // ==========================================================
  // Status mirror to the port
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prot_locked_q <= SMP_LOCK_RST;
    else
      prot_locked_q <= locked;
  end

  // ==========================================================
  // Register whose bits are all protected
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prot_ctrl_q <= SMP_PROT_CTRL_RST;
    else if (wr && hit_pc && !locked)
      prot_ctrl_q <= wdata;
  end

  // ==========================================================
  // Paged module in the mapped area
  always_comb
  begin
    pg_bus.wr    = wr && hit_pg;
    pg_bus.addr  = addr[SMP_PAGE_WIN_W-1:0];
    pg_bus.wdata = wdata;
  end

  smp_paged_regs #(
    .PAGES (PAGES),
    .REGS  (REGS)
  ) u_paged (
    .clk   (clk),
    .rst_n (rst_n),
    .bus   (pg_bus.page)
  );

  // ==========================================================
  // Read views of the local registers
  always_comb
  begin
    sys_view                  = 8'h00;
    sys_view[SMP_RSV_ONE_BIT] = 1'b1;
    sys_view[SMP_AREA_BIT]    = area_select_q;
    sys_view[SMP_IMODE_BIT]   = idle_mode_q;
    pw_view                   = 8'h00;
    pw_view[SMP_MODE_LSB +: 2] = prot_mode_q;
    pw_view[SMP_STATUS_BIT]   = locked;
  end

  // ==========================================================
  // Read data mux
  always_comb
  begin
    rdata_d = 8'h00;
    if (rd)
    begin
      if (hit_sys)
        rdata_d = sys_view;
      else if (hit_pw)
        rdata_d = pw_view;
      else if (hit_pc)
        rdata_d = prot_ctrl_q;
      else if (hit_pg)
        rdata_d = pg_bus.rdata;
    end
  end

  // ==========================================================
  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  // ==========================================================
  // Accesses not served here go out tagged with their area
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fwd_wr_q    <= 1'b0;
      fwd_rd_q    <= 1'b0;
      fwd_area_q  <= 1'b0;
      fwd_addr_q  <= 8'h00;
      fwd_wdata_q <= 8'h00;
    end
    else
    begin
      fwd_wr_q <= wr && !hit_any;
      fwd_rd_q <= rd && !hit_any;
      if ((wr || rd) && !hit_any)
      begin
        // Full 8-bit address per area
        fwd_area_q  <= area_select_q;
        fwd_addr_q  <= addr;
        fwd_wdata_q <= wdata;
      end
    end
  end

endmodule : smp_top

`default_nettype wire
